// ==== verilog/uab_pkg.sv ====
// Purpose: shared constants and types for the uart break and receive block
// Assumes: 32-bit ahb-lite register port, one word per register
// Notes:   all offsets are byte addresses
package uab_pkg;
  localparam logic [7:0] OFF_STATUS  = 8'h00;
  localparam logic [7:0] OFF_CONTROL = 8'h04;
  localparam logic [7:0] OFF_DATA    = 8'h08;
  localparam logic [7:0] OFF_BAUD    = 8'h0C;
  // control fields
  localparam int CB_RX_ENABLE_BIT   = 0;
  localparam int CB_NINE   = 1;
  localparam int CB_PARITY_ENABLE   = 2;
  localparam int CB_ODD    = 3;
  localparam int CB_TWOSTP = 4;
  localparam int CB_BRK    = 5;
  localparam int CB_RIE    = 6;
  localparam int CB_RX9    = 7;
  // status fields and register reset values
  localparam int SB_PARITY_ERROR_FLAG = 0;
  localparam int SB_FRAMING_ERROR_FLAG = 1;
  localparam int SB_NF   = 2;
  localparam int SB_OVERRUN_FLAG = 3;
  localparam int SB_RIDL = 4;
  localparam int SB_RDY  = 5;
  localparam int SB_TIDL = 6;
  localparam int SB_TBE  = 7;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  // oversampling, frame timing and receive buffer depth
  localparam logic [3:0] OS_LAST  = 4'hF;
  localparam logic [3:0] OS_S0    = 4'h7;
  localparam logic [3:0] OS_S1    = 4'h8;
  localparam logic [3:0] OS_S2    = 4'h9;
  localparam logic [3:0] BRK_ZERO = 4'hD;
  localparam logic [1:0] FIFO_DEP = 2'h2;
  typedef struct packed {
    logic       ninth;
    logic [7:0] low;
  } uab_word_t;
  typedef enum logic [2:0] {
    RX_HUNT = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2,
    RX_STOP1 = 3'h3, RX_STOP2 = 3'h4, RX_WAITHI = 3'h5
  } uab_rx_st_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0, TX_START = 2'h1, TX_BRK = 2'h2, TX_STOP = 2'h3
  } uab_tx_st_t;
endpackage : uab_pkg

// ==== verilog/uab_vote.sv ====
// Purpose: three-sample majority vote of the rx line within one bit
// Assumes: rx_in already synchronised to hclk
// Notes:   result appears one cycle after the third sample
`timescale 1ns/1ps
module uab_vote (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ce,
  input  wire logic       os_tick,
  input  wire logic [3:0] os_cnt,
  input  wire logic       rx_in,
  output logic            bit_vld,
  output logic            bit_val,
  output logic            bit_noise
);
  logic s0;
  logic s1;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s0 <= 1'b1;
      s1 <= 1'b1;
    end
    else if (ce && os_tick)
    begin
      if (os_cnt == uab_pkg::OS_S0)
        s0 <= rx_in;
      if (os_cnt == uab_pkg::OS_S1)
        s1 <= rx_in;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bit_vld   <= 1'b0;
      bit_val   <= 1'b1;
      bit_noise <= 1'b0;
    end
    else if (ce)
    begin
      bit_vld <= os_tick && (os_cnt == uab_pkg::OS_S2);
      if (os_tick && (os_cnt == uab_pkg::OS_S2))
      begin
        bit_val   <= (s0 & s1) | (s0 & rx_in) | (s1 & rx_in);
        bit_noise <= !((s0 == s1) && (s1 == rx_in));
      end
    end
  end
endmodule : uab_vote

// ==== verilog/uab_uart.sv ====
// Purpose: uart break transmit and receive path behind an ahb-lite slave
// Assumes: 200 MHz hclk, single word transfers, zero wait states
// Notes:   normal data transmit is outside this block
// Contract
// - status access then data write clears tx flags
// - break is start plus 13xN zeros
// - break repeats while set, then stop bits
// - nine-bit mode stores msb in rx_ninth_bit
// - recovery at 16x, shifter at bit rate
// - each bit decided by three-sample majority
// - word moves to buffer after stop, if room
// - lsb arrives and is stored first
// - two buffered words, third overruns and drops
// - overrun keeps buffer, flags, requests interrupt
// - status access then data read clears overrun
// - rx enable starts hunting for start bit
// - ready while buffered, interrupt per transfer
// - status access then data read clears ready
// - long break ends after frame, loads zeros
// - after framing error wait for high line
// - idle low during frame, high between frames
// - noise flagged with ready, data still kept
// - status read then data read clears noise
// - any low stop bit sets framing error
// - parity mismatch sets parity error when enabled
// - control selects two_stop_select, parity type, parity on
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module uab_uart (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rx_pin,
  output logic             tx_pin,
  output logic             rx_irq_req
);
  logic [6:0]          ctrl;
  logic [7:0]          baud_divisor_reg;
  logic                wr_pend;
  logic [7:0]          wr_addr;
  logic                armed;
  logic                overrun_flag;
  logic                noise_flag;
  logic                framing_error_flag;
  logic                parity_error_flag;
  logic                rx_idle_flag;
  logic                tx_idle_flag;
  logic                tx_buffer_empty_flag;
  logic                rx_data_ready_flag;
  logic                rx_meta;
  logic                rx_s;
  logic [9:0]          pres;
  logic                os_tick;
  logic [3:0]          os_cnt;
  uab_pkg::uab_rx_st_t rx_st;
  logic [8:0]          rx_shift_reg;
  logic [3:0]          bit_cnt;
  logic                noise_acc;
  logic                stop_bad;
  logic                bit_vld;
  logic                bit_val;
  logic                bit_noise;
  logic                frame_end;
  logic                last_stop;
  uab_pkg::uab_word_t  rx_word;
  uab_pkg::uab_word_t  fifo_mem [2];
  logic                wp;
  logic                rp;
  logic [1:0]          fifo_cnt;
  logic                push;
  logic                pop;
  logic                rd_req;
  logic                wr_data;
  logic                seq_clr;
  uab_pkg::uab_tx_st_t tx_st;
  logic [3:0]          tx_os;
  logic [3:0]          tx_bits;

  wire rx_enable_bit     = ctrl[uab_pkg::CB_RX_ENABLE_BIT];
  wire nine_bit_select   = ctrl[uab_pkg::CB_NINE];
  wire parity_enable     = ctrl[uab_pkg::CB_PARITY_ENABLE];
  wire parity_odd_select = ctrl[uab_pkg::CB_ODD];
  wire two_stop_select   = ctrl[uab_pkg::CB_TWOSTP];
  wire send_break_bit    = ctrl[uab_pkg::CB_BRK];
  wire rx_irq_enable     = ctrl[uab_pkg::CB_RIE];
  // ninth bit of the head word
  wire rx_ninth_bit      = fifo_mem[rp].ninth;
  wire tx_bit_end        = os_tick && (tx_os == uab_pkg::OS_LAST);

  assign rd_req    = hsel && hready && htrans[1] && !hwrite;
  assign wr_data   = wr_pend && (wr_addr == uab_pkg::OFF_DATA);
  // a data read pops the head word, ready falls when empty
  assign pop       = rd_req && (haddr[7:0] == uab_pkg::OFF_DATA) && (fifo_cnt != 2'h0);
  assign seq_clr   = armed && rd_req && (haddr[7:0] == uab_pkg::OFF_DATA);
  assign last_stop = (rx_st == uab_pkg::RX_STOP2) ||
                     ((rx_st == uab_pkg::RX_STOP1) && !two_stop_select);
  assign frame_end = bit_vld && last_stop;
  assign push      = frame_end && (fifo_cnt != uab_pkg::FIFO_DEP);
  // lsb landed in the low bit after the full shift
  assign rx_word   = nine_bit_select ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
  assign rx_data_ready_flag = (fifo_cnt != 2'h0);

  // ahb-lite slave: zero wait, always okay, unmapped reads as zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
    end
    else if (ce)
    begin
      wr_pend <= hsel && hready && htrans[1] && hwrite && (hsize == 3'h2);
      wr_addr <= haddr[7:0];
      if (rd_req)
      begin
        case (haddr[7:0])
          uab_pkg::OFF_STATUS:
            hrdata <= {24'h00_0000, tx_buffer_empty_flag, tx_idle_flag,
                       rx_data_ready_flag, rx_idle_flag, overrun_flag,
                       noise_flag, framing_error_flag, parity_error_flag};
          uab_pkg::OFF_CONTROL: hrdata <= {24'h00_0000, rx_ninth_bit, ctrl};
          uab_pkg::OFF_DATA:    hrdata <= {24'h00_0000, fifo_mem[rp].low};
          uab_pkg::OFF_BAUD:    hrdata <= {24'h00_0000, baud_divisor_reg};
          default:              hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control and baud registers steer the frame format
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl             <= uab_pkg::CTRL_RST;
      baud_divisor_reg <= uab_pkg::BAUD_RST;
    end
    else if (ce && wr_pend)
    begin
      if (wr_addr == uab_pkg::OFF_CONTROL)
        ctrl <= hwdata[6:0];
      if (wr_addr == uab_pkg::OFF_BAUD)
        baud_divisor_reg <= hwdata[7:0];
    end
  end

  // a status read arms the clearing sequence; any data access ends it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      armed <= 1'b0;
    else if (ce)
    begin
      if (rd_req && (haddr[7:0] == uab_pkg::OFF_STATUS))
        armed <= 1'b1;
      else if (wr_data || (rd_req && (haddr[7:0] == uab_pkg::OFF_DATA)))
        armed <= 1'b0;
    end
  end

  // rx pin crosses in from outside through two flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_meta <= 1'b1;
      rx_s    <= 1'b1;
    end
    else if (ce)
    begin
      rx_meta <= rx_pin;
      rx_s    <= rx_meta;
    end
  end

  // 16x tick: 4*(divisor+1) clocks per tick
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pres    <= 10'h000;
      os_tick <= 1'b0;
    end
    else if (ce)
    begin
      os_tick <= (pres == {baud_divisor_reg, 2'h3});
      if (pres == {baud_divisor_reg, 2'h3})
        pres <= 10'h000;
      else
        pres <= pres + 10'h001;
    end
  end

  uab_vote u_vote (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .os_tick   (os_tick),
    .os_cnt    (os_cnt),
    .rx_in     (rx_s),
    .bit_vld   (bit_vld),
    .bit_val   (bit_val),
    .bit_noise (bit_noise)
  );

  // receive sequencer; the shifter advances once per bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_st        <= uab_pkg::RX_HUNT;
      os_cnt       <= 4'h0;
      bit_cnt      <= 4'h0;
      rx_shift_reg <= 9'h000;
      noise_acc    <= 1'b0;
      stop_bad     <= 1'b0;
      rx_idle_flag <= 1'b1;
    end
    else if (ce)
    begin
      if (os_tick)
        os_cnt <= os_cnt + 4'h1;
      if (bit_vld)
        noise_acc <= noise_acc | bit_noise;
      case (rx_st)
        uab_pkg::RX_HUNT:
          if (rx_enable_bit && os_tick && !rx_s)
          begin
            rx_st        <= uab_pkg::RX_START;
            os_cnt       <= 4'h1;
            noise_acc    <= 1'b0;
            stop_bad     <= 1'b0;
            bit_cnt      <= 4'h0;
            rx_idle_flag <= 1'b0;
          end
        uab_pkg::RX_START:
          if (bit_vld && bit_val)
          begin
            rx_st        <= uab_pkg::RX_HUNT;
            rx_idle_flag <= 1'b1;
          end
          else if (os_tick && (os_cnt == uab_pkg::OS_LAST))
            rx_st <= uab_pkg::RX_DATA;
        uab_pkg::RX_DATA:
        begin
          // lsb first into the top, shifting down
          if (bit_vld)
          begin
            rx_shift_reg <= {bit_val, rx_shift_reg[8:1]};
            bit_cnt      <= bit_cnt + 4'h1;
          end
          if (os_tick && (os_cnt == uab_pkg::OS_LAST) &&
              (bit_cnt == (nine_bit_select ? 4'h9 : 4'h8)))
            rx_st <= uab_pkg::RX_STOP1;
        end
        uab_pkg::RX_STOP1, uab_pkg::RX_STOP2:
        begin
          // every stop bit must be high
          if (bit_vld && !bit_val)
            stop_bad <= 1'b1;
          if (frame_end)
          begin
            // a bad stop forces a wait for high line
            rx_st        <= (stop_bad || !bit_val) ? uab_pkg::RX_WAITHI : uab_pkg::RX_HUNT;
            rx_idle_flag <= 1'b1;
          end
          else if (os_tick && (os_cnt == uab_pkg::OS_LAST))
            rx_st <= uab_pkg::RX_STOP2;
        end
        uab_pkg::RX_WAITHI:
          if (os_tick && rx_s)
            rx_st <= uab_pkg::RX_HUNT;
        default: rx_st <= uab_pkg::RX_HUNT;
      endcase
      if (!rx_enable_bit)
        rx_st <= uab_pkg::RX_HUNT;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wp       <= 1'b0;
      rp       <= 1'b0;
      fifo_cnt <= 2'h0;
      fifo_mem <= '{default: '0};
    end
    else if (ce)
    begin
      // transfer only with room; a break stores zeros
      if (push)
      begin
        fifo_mem[wp] <= rx_word;
        wp           <= !wp;
      end
      if (pop)
        rp <= !rp;
      fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // error flags: a new event wins over the clearing sequence
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      overrun_flag       <= 1'b0;
      noise_flag         <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag  <= 1'b0;
      rx_irq_req         <= 1'b0;
    end
    else if (ce)
    begin
      // sequence clears; errors kept until data read
      if (seq_clr)
      begin
        overrun_flag       <= 1'b0;
        noise_flag         <= 1'b0;
        framing_error_flag <= 1'b0;
        parity_error_flag  <= 1'b0;
      end
      // full buffer: word dropped, flag set
      if (frame_end && !push)
        overrun_flag <= 1'b1;
      if (push && (noise_acc || bit_noise))
        noise_flag <= 1'b1;
      if (frame_end && (stop_bad || !bit_val))
        framing_error_flag <= 1'b1;
      // even parity expects an even count of ones
      if (frame_end && parity_enable && ((^rx_word) != parity_odd_select))
        parity_error_flag <= 1'b1;
      // one request per transfer or overrun
      rx_irq_req <= frame_end && rx_irq_enable;
    end
  end

  // break transmitter, paced by the same 16x tick
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_st   <= uab_pkg::TX_IDLE;
      tx_os   <= 4'h0;
      tx_bits <= 4'h0;
      tx_pin  <= 1'b1;
    end
    else if (ce)
    begin
      if (os_tick)
        tx_os <= tx_os + 4'h1;
      case (tx_st)
        uab_pkg::TX_IDLE:
          // start on a tick, else the start bit is up to one tick short
          if (send_break_bit && os_tick)
          begin
            tx_st  <= uab_pkg::TX_START;
            tx_os  <= 4'h0;
            tx_pin <= 1'b0;
          end
        uab_pkg::TX_START:
          if (tx_bit_end)
          begin
            tx_st   <= uab_pkg::TX_BRK;
            tx_bits <= 4'h0;
          end
        uab_pkg::TX_BRK:
          if (tx_bit_end)
          begin
            tx_bits <= tx_bits + 4'h1;
            if (tx_bits == uab_pkg::BRK_ZERO - 4'h1)
            begin
              tx_bits <= 4'h0;
              if (!send_break_bit)
              begin
                tx_st  <= uab_pkg::TX_STOP;
                tx_pin <= 1'b1;
              end
            end
          end
        uab_pkg::TX_STOP:
          if (tx_bit_end)
          begin
            tx_bits <= tx_bits + 4'h1;
            if (tx_bits == {3'h0, two_stop_select})
              tx_st <= uab_pkg::TX_IDLE;
          end
        default: tx_st <= uab_pkg::TX_IDLE;
      endcase
    end
  end

  // tx flags; break sets no tx request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_idle_flag         <= 1'b1;
      tx_buffer_empty_flag <= 1'b1;
    end
    else if (ce)
    begin
      if (armed && wr_data)
      begin
        tx_idle_flag         <= 1'b0;
        tx_buffer_empty_flag <= 1'b0;
      end
      else if (tx_st == uab_pkg::TX_IDLE)
        tx_buffer_empty_flag <= 1'b1;
      if (tx_st == uab_pkg::TX_START)
        tx_idle_flag <= 1'b0;
      if ((tx_st == uab_pkg::TX_STOP) && tx_bit_end &&
          (tx_bits == {3'h0, two_stop_select}))
        tx_idle_flag <= 1'b1;
    end
  end

  a_push_room: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && push && !pop) |=> (fifo_cnt == $past(fifo_cnt) + 2'h1))
    else $error("word not stored with room");
  a_overrun_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && frame_end && fifo_cnt == 2'h2 && !pop) |=> overrun_flag && fifo_cnt == 2'h2)
    else $error("overrun not handled");
  a_seq_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && seq_clr && !frame_end) |=> !overrun_flag && !noise_flag)
    else $error("clear sequence failed");
  a_rx_disabled: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !rx_enable_bit) |=> rx_st == uab_pkg::RX_HUNT)
    else $error("receiver active while disabled");
  a_irq_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && push && rx_irq_enable) |=> rx_irq_req ##1 !rx_irq_req)
    else $error("missing transfer request");
  a_idle_frame: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && rx_st == uab_pkg::RX_HUNT && rx_enable_bit && os_tick && !rx_s)
    |=> !rx_idle_flag)
    else $error("idle not cleared at start");
  a_noise_ready: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && push && noise_acc) |=> noise_flag && rx_data_ready_flag)
    else $error("noise not flagged with data");
  a_stop_framing_error_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && frame_end && !bit_val) |=> framing_error_flag ##1 rx_st == $past(rx_st))
    else $error("low stop not flagged");
  a_parity_err: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && frame_end && parity_enable && ((^rx_word) != parity_odd_select))
    |=> parity_error_flag)
    else $error("parity error missed");
  a_break_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_st == uab_pkg::TX_BRK) |-> !tx_pin)
    else $error("break line not low");
endmodule : uab_uart

// ==== sim/uab_far_end.sv ====
// Purpose: remote serial transmitter that drives the block's rx line
// Assumes: BIT is the bit time in hclk cycles for the chosen baud divisor
// Notes:   line idles high, which doubles as the stop level
`timescale 1ns/1ps
module uab_far_end #(
  parameter int BIT = 64
) (
  input  wire logic hclk,
  output logic      line
);
  initial line = 1'b1;

  task automatic bit_out(input logic v, input bit glitch);
    @(posedge hclk);
    line <= v;
    // a short flip spans one 4-cycle tick, so it spoils one vote only
    if (glitch)
    begin
      repeat (32) @(posedge hclk);
      line <= ~v;
      repeat (4) @(posedge hclk);
      line <= v;
      repeat (BIT - 37) @(posedge hclk);
    end
    else
      repeat (BIT - 1) @(posedge hclk);
  endtask : bit_out

  task automatic send(input logic [8:0] w, input int nb, input int ns,
                      input logic st2, input bit noisy);
    bit_out(1'b0, 1'b0);
    for (int i = 0; i < nb; i++)
      bit_out(w[i], noisy && i == 0);
    bit_out(1'b1, 1'b0);
    if (ns == 2)
      bit_out(st2, 1'b0);
    bit_out(1'b1, 1'b0);
  endtask : send

  task automatic hold_low(input int nbits);
    @(posedge hclk);
    line <= 1'b0;
    repeat (nbits * BIT) @(posedge hclk);
    line <= 1'b1;
    repeat (2 * BIT) @(posedge hclk);
  endtask : hold_low
endmodule : uab_far_end

// ==== sim/tb.sv ====
// Purpose: register-level bench for the uart break and receive block
// Assumes: baud divisor 0, so one bit is 64 hclk cycles
// Notes:   ce is tied high; the far end drives rx_pin
`timescale 1ns/1ps
module tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout;
  logic        hresp;
  logic        rx_pin;
  logic        tx_pin;
  logic        rx_irq_req;
  int          fails = 0;
  int          n_checks = 0;
  int          irqs = 0;
  int          cyc = 0;
  int          low_cnt = 0;
  logic [6:0]  tc[5] = '{7'h43, 7'h4D, 7'h4D, 7'h51, 7'h41};
  logic [8:0]  tw[5] = '{9'h1C5, 9'h083, 9'h003, 9'h05A, 9'h096};
  logic [5:0]  es[5] = '{6'h30, 6'h30, 6'h31, 6'h32, 6'h34};
  int          tn[5] = '{9, 8, 8, 8, 8};
  int          ns[5] = '{1, 1, 1, 2, 1};

  uab_uart uut (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ce         (1'b1),
    .hsel       (hsel),
    .haddr      (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hsize      (hsize),
    .hwdata     (hwdata),
    .hready     (hreadyout),
    .hrdata     (hrdata),
    .hreadyout  (hreadyout),
    .hresp      (hresp),
    .rx_pin     (rx_pin),
    .tx_pin     (tx_pin),
    .rx_irq_req (rx_irq_req)
  );

  uab_far_end #(.BIT(64)) far (
    .hclk (hclk),
    .line (rx_pin)
  );

  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // a hang ends the run as a failure
  always @(posedge hclk)
  begin
    cyc++;
    if (rx_irq_req === 1'b1)
      irqs++;
    if (tx_pin === 1'b0)
      low_cnt++;
    if (cyc == 40000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // status first, then data, so error flags are seen before the pop
  task automatic rx_chk(input logic [7:0] ed, input logic [5:0] st);
    ahb(1'b0, uab_pkg::OFF_STATUS, 32'h0);
    chk("status", {26'h0, st}, {26'h0, rd[5:0]});
    ahb(1'b0, uab_pkg::OFF_DATA, 32'h0);
    chk("data", {24'h0, ed}, {24'h0, rd[7:0]});
  endtask : rx_chk

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, uab_pkg::OFF_STATUS, 32'h0);
    chk("status_rst", 32'h000000D0, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
    ahb(1'b0, uab_pkg::OFF_CONTROL, 32'h0);
    chk("control_rst", 32'h00000000, rd);
    ahb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h00000000, rd);
    ahb(1'b1, uab_pkg::OFF_BAUD, 32'h0);
    ahb(1'b0, uab_pkg::OFF_STATUS, 32'h0);
    ahb(1'b1, uab_pkg::OFF_DATA, 32'h00000055);
    ahb(1'b0, uab_pkg::OFF_STATUS, 32'h0);
    chk("tx_idle_clr", 32'h0, {31'h0, rd[6]});
    // receiver off: frame must be ignored
    ahb(1'b1, uab_pkg::OFF_CONTROL, 32'h00000040);
    far.send(9'h05A, 8, 1, 1'b1, 1'b0);
    rx_chk(8'h00, 6'h10);
    ahb(1'b1, uab_pkg::OFF_CONTROL, 32'h00000041);
    fork
      far.send(9'h0A5, 8, 1, 1'b1, 1'b0);
      begin
        repeat (320) @(posedge hclk);
        ahb(1'b0, uab_pkg::OFF_STATUS, 32'h0);
        chk("idle_mid", 32'h0, {31'h0, rd[4]});
      end
    join
    chk("irqs", 32'd1, irqs);
    rx_chk(8'hA5, 6'h30);
    ahb(1'b0, uab_pkg::OFF_STATUS, 32'h0);
    chk("ready_clr", 32'h0, {31'h0, rd[5]});
    far.send(9'h011, 8, 1, 1'b1, 1'b0);
    far.send(9'h022, 8, 1, 1'b1, 1'b0);
    far.send(9'h033, 8, 1, 1'b1, 1'b0);
    chk("irqs_ovr", 32'd4, irqs);
    rx_chk(8'h11, 6'h38);
    ahb(1'b0, uab_pkg::OFF_DATA, 32'h0);
    chk("data2", 32'h22, {24'h0, rd[7:0]});
    ahb(1'b0, uab_pkg::OFF_STATUS, 32'h0);
    chk("ovr_clr", 32'h10, {26'h0, rd[5:0]});
    for (int i = 0; i < 5; i++)
    begin
      ahb(1'b1, uab_pkg::OFF_CONTROL, {25'h0, tc[i]});
      far.send(tw[i], tn[i], ns[i], i != 3, i == 4);
      ahb(1'b0, uab_pkg::OFF_STATUS, 32'h0);
      chk("status_fmt", {26'h0, es[i]}, {26'h0, rd[5:0]});
      ahb(1'b0, uab_pkg::OFF_CONTROL, 32'h0);
      chk("ninth", {31'h0, tw[i][8]}, {31'h0, rd[7]});
      ahb(1'b0, uab_pkg::OFF_DATA, 32'h0);
      chk("data_fmt", {24'h0, tw[i][7:0]}, {24'h0, rd[7:0]});
    end
    ahb(1'b1, uab_pkg::OFF_CONTROL, 32'h00000041);
    far.hold_low(20);
    rx_chk(8'h00, 6'h32);
    far.send(9'h03C, 8, 1, 1'b1, 1'b0);
    rx_chk(8'h3C, 6'h30);
    low_cnt = 0;
    ahb(1'b1, uab_pkg::OFF_CONTROL, 32'h00000020);
    repeat (1280) @(posedge hclk);
    ahb(1'b1, uab_pkg::OFF_CONTROL, 32'h00000000);
    @(posedge hclk);
    while (tx_pin !== 1'b1) @(posedge hclk);
    repeat (128) @(posedge hclk);
    chk("break_len", 32'd1728, low_cnt);
    ahb(1'b0, uab_pkg::OFF_STATUS, 32'h0);
    chk("tx_idle_set", 32'h1, {31'h0, rd[6]});
    tally_and_finish();
  end
endmodule : tb
